// ---- rtl/rdc_pkg.sv ----
/*
  Shared constants and types for the clock-correction block of the
  real-time clock: register offsets, field positions, reset values,
  divide ratios and the register request carrier.
  Assumes a single 40 MHz core clock and a register port driven by the
  serial host interface logic that sits outside this block.
*/
package rdc_pkg;

  // Core clock period, for reference by derived counts.
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Register offsets.
  localparam logic [7:0] RATE_TRIM_OFS = 8'h08;
  localparam logic [7:0] CAP_TRIM_OFS = 8'h12;

  // Digital trim fields.
  localparam int unsigned RATE_MAG_LSB = 0;
  localparam int unsigned RATE_MAG_W = 5;
  localparam int unsigned RATE_SIGN_BIT = 5;
  localparam int unsigned RATE_REG_W = 6;
  localparam logic [5:0] RATE_TRIM_RST = 6'h00;

  // Analog trim fields.
  localparam int unsigned CAP_SIGN_BIT = 7;
  localparam int unsigned CAP_MAG_W = 7;
  localparam logic [7:0] CAP_TRIM_RST = 8'h00;
  // Default code: zero magnitude, nominal load on both crystal sides.
  localparam logic [7:0] CAP_DEFAULT_CODE = 8'h00;
  // Largest magnitude that adds capacitance (sign clear), in quarter pF.
  localparam logic [6:0] CAP_ADD_MAX = 7'h27;
  // Largest magnitude that removes capacitance (sign set), in quarter pF.
  localparam logic [6:0] CAP_SUB_MAX = 7'h48;

  // Divider ratios: input pulses from the 512 Hz stage per 100 outputs.
  localparam logic [9:0] DIV_OUT_PER_SEC = 10'h064;
  localparam logic [9:0] DIV_NORMAL = 10'h200;
  localparam logic [9:0] DIV_FAST = 10'h1FF;
  localparam logic [9:0] DIV_SLOW = 10'h201;
  localparam logic [9:0] DIV_RST = 10'h200;

  // Correction cycle positions.
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [3:0] MIN_MOD_MASK_FAST = 4'h7;
  localparam logic [3:0] MIN_MOD_MASK_SLOW = 4'hF;

  // Register read data for unmapped offsets and reserved bits.
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // One register access request from the host interface.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rdc_reg_req_t;

endpackage : rdc_pkg

// ---- rtl/rdc_div.sv ----
/*
  Hundred-hertz divider stage: turns pulses from the 512 Hz stage into
  100 output pulses per programmable number of input pulses.
  Assumes the ratio input is changed only at a second boundary, when the
  accumulator is back at zero.
*/
`timescale 1ns/1ps
module rdc_div (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Timebase and ratio.
  input wire logic in_pulse_i,
  input wire logic [9:0] ratio_i,
  // Outputs.
  output logic out_pulse_o,
  output logic sec_end_o
);

  logic [9:0] acc_ff;
  logic [6:0] cnt_ff;
  logic [9:0] acc_sum;
  logic emit;
  logic last;

  // Spreading by accumulation gives exactly 100 pulses per ratio inputs
  // and leaves the accumulator at zero after the hundredth.
  assign acc_sum = acc_ff + rdc_pkg::DIV_OUT_PER_SEC;
  assign emit = in_pulse_i && (acc_sum >= ratio_i);
  assign last = (cnt_ff == 7'(rdc_pkg::DIV_OUT_PER_SEC - 10'h001));

  // Accumulator and output counter.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      acc_ff <= 10'h000;
      cnt_ff <= 7'h00;
      out_pulse_o <= 1'b0;
      sec_end_o <= 1'b0;
    end else begin
      out_pulse_o <= emit;
      sec_end_o <= emit && last;
      if (in_pulse_i) begin
        acc_ff <= emit ? acc_sum - ratio_i : acc_sum;
      end
      if (emit) begin
        cnt_ff <= last ? 7'h00 : cnt_ff + 7'h01;
      end
    end
  end

endmodule : rdc_div

// ---- rtl/rdc_calib.sv ----
/*
  Clock-correction block of the real-time clock: digital periodic
  counter correction of the 100 Hz stage, analog load trim register and
  the frequency-test output.
  Assumes a 1024 Hz one-cycle tick from the oscillator divider chain,
  synchronous to the core clock, and a register request port driven by
  the serial host interface.
*/
// Contract
// - Uncorrected divider emits 100 pulses per 512 input pulses.
// - Positive corrected second: 100 pulses per 511 input pulses.
// - Negative corrected second: 100 pulses per 513 input pulses.
// - Correct first N seconds of each 8 or 16 minute cycle.
// - Magnitude is a 5-bit field, low bits of register 08h.
// - Bit 5 of 08h: one speeds up, zero slows down.
// - Zero magnitude never corrects, whatever the sign.
// - Frequency-test output is independent of the digital trim.
// - When enabled, 512 Hz square wave drives the shared test pin.
// - Bit 7 of 12h is cap sign above seven magnitude bits.
// - Invalid analog code falls back to the default capacitor setting.
`timescale 1ns/1ps
module rdc_calib (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Timebase from the oscillator divider chain.
  input wire logic tick_1024_i,
  // Register access from the host interface.
  input wire rdc_pkg::rdc_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Shared test/interrupt pin.
  input wire logic freq_test_output_i,
  input wire logic irq_level_i,
  output logic shared_irq_test_pin_o,
  // Timekeeping outputs.
  output logic hund_pulse_o,
  output logic sec_tick_o,
  output logic corr_active_o,
  output logic [7:0] load_cap_code_o
);

  // Registers.
  logic [5:0] rate_trim_ff;
  logic [7:0] cap_trim_ff;
  logic half_ff;
  logic [5:0] sec_ff;
  logic [3:0] min_ff;
  logic [9:0] ratio_ff;

  // Combinational helpers.
  logic wr_rate;
  logic wr_cap;
  logic tick_512;
  logic div_pulse;
  logic div_sec_end;
  logic [5:0] nxt_sec;
  logic [3:0] nxt_min;
  logic [4:0] rate_trim_magnitude;
  logic rate_trim_sign;
  logic [3:0] cycle_mask;
  logic cycle_start;
  logic nxt_active;
  logic [9:0] nxt_ratio;
  logic cap_trim_sign;
  logic [6:0] cap_trim_magnitude;
  logic cap_valid;
  logic [7:0] nxt_cap_code;
  logic [7:0] nxt_rdata;

  // Register decode; the two trim registers sit at their own offsets.
  assign wr_rate = reg_req_i.wr && (reg_req_i.addr == rdc_pkg::RATE_TRIM_OFS);
  assign wr_cap = reg_req_i.wr && (reg_req_i.addr == rdc_pkg::CAP_TRIM_OFS);

  // Host-written trim registers.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rate_trim_ff <= rdc_pkg::RATE_TRIM_RST;
      cap_trim_ff <= rdc_pkg::CAP_TRIM_RST;
    end else begin
      if (wr_rate) begin
        rate_trim_ff <= reg_req_i.wdata[5:0];
      end
      if (wr_cap) begin
        cap_trim_ff <= reg_req_i.wdata;
      end
    end
  end

  // Read mux; bits above the digital trim field read as zero.
  assign nxt_rdata =
    (reg_req_i.addr == rdc_pkg::RATE_TRIM_OFS) ? {2'b00, rate_trim_ff} :
    (reg_req_i.addr == rdc_pkg::CAP_TRIM_OFS) ? cap_trim_ff :
    rdc_pkg::RDATA_NONE;

  // Read data holds until the next read request.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= rdc_pkg::RDATA_NONE;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // The 512 Hz stage: the half-rate flop is both the square wave and the
  // pulse gate. It never sees the trim, so the test pin cannot show it.
  assign tick_512 = tick_1024_i && half_ff;

  // 512 Hz stage and the shared test pin.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      half_ff <= 1'b0;
      shared_irq_test_pin_o <= 1'b0;
    end else begin
      if (tick_1024_i) begin
        half_ff <= ~half_ff;
      end
      shared_irq_test_pin_o <= freq_test_output_i ? half_ff
                                                  : irq_level_i;
    end
  end

  // Hundred-hertz stage with its ratio chosen once per second.
  rdc_div u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_pulse_i(tick_512),
    .ratio_i(ratio_ff),
    .out_pulse_o(div_pulse),
    .sec_end_o(div_sec_end)
  );

  // Running seconds and minutes within the longest correction cycle.
  assign nxt_sec = (sec_ff == rdc_pkg::SEC_LAST) ? 6'h00 : sec_ff + 6'h01;
  assign nxt_min = (sec_ff == rdc_pkg::SEC_LAST) ? min_ff + 4'h1 : min_ff;

  // The written value is sampled at the boundary, so a write in the middle
  // of a second cannot bend a second already under way.
  assign rate_trim_magnitude = rate_trim_ff[rdc_pkg::RATE_MAG_W-1:0];
  assign rate_trim_sign = rate_trim_ff[rdc_pkg::RATE_SIGN_BIT];

  // Positive correction repeats every 8 minutes, negative every 16.
  assign cycle_mask = rate_trim_sign ? rdc_pkg::MIN_MOD_MASK_FAST
                                     : rdc_pkg::MIN_MOD_MASK_SLOW;
  assign cycle_start = ((nxt_min & cycle_mask) == 4'h0);
  assign nxt_active = (rate_trim_magnitude != 5'h00) && cycle_start &&
                      (nxt_sec < {1'b0, rate_trim_magnitude});
  assign nxt_ratio = !nxt_active ? rdc_pkg::DIV_NORMAL :
                     rate_trim_sign ? rdc_pkg::DIV_FAST :
                     rdc_pkg::DIV_SLOW;

  // Second boundary: advance the count, take the new trim, pick the ratio.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sec_ff <= 6'h00;
      min_ff <= 4'h0;
      ratio_ff <= rdc_pkg::DIV_RST;
      corr_active_o <= 1'b0;
    end else if (div_sec_end) begin
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      ratio_ff <= nxt_ratio;
      corr_active_o <= nxt_active;
    end
  end

  // Pulse outputs toward the fraction-of-seconds counter.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      hund_pulse_o <= 1'b0;
      sec_tick_o <= 1'b0;
    end else begin
      hund_pulse_o <= div_pulse;
      sec_tick_o <= div_sec_end;
    end
  end

  // Analog trim: a magnitude beyond the reachable range for its sign is
  // not a capacitor setting, so the network gets the default instead.
  assign cap_trim_sign = cap_trim_ff[rdc_pkg::CAP_SIGN_BIT];
  assign cap_trim_magnitude = cap_trim_ff[rdc_pkg::CAP_MAG_W-1:0];
  assign cap_valid = cap_trim_sign ?
                     (cap_trim_magnitude <= rdc_pkg::CAP_SUB_MAX) :
                     (cap_trim_magnitude <= rdc_pkg::CAP_ADD_MAX);
  assign nxt_cap_code = cap_valid ? cap_trim_ff
                                  : rdc_pkg::CAP_DEFAULT_CODE;

  // Capacitor network control word.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      load_cap_code_o <= rdc_pkg::CAP_DEFAULT_CODE;
    end else begin
      load_cap_code_o <= nxt_cap_code;
    end
  end

endmodule : rdc_calib

// ---- bench/rdc_calib_checker.sv ----
/* Port assertions for the correction block.
   Assumes one core clock and binding onto rdc_calib. */
`timescale 1ns/1ps
module rdc_calib_checker (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Inputs.
  input wire logic tick_1024_i,
  input wire rdc_pkg::rdc_reg_req_t reg_req_i,
  input wire logic freq_test_output_i,
  input wire logic irq_level_i,
  // Outputs.
  input wire logic [7:0] reg_rdata_o,
  input wire logic shared_irq_test_pin_o,
  input wire logic hund_pulse_o,
  input wire logic sec_tick_o,
  input wire logic corr_active_o,
  input wire logic [7:0] load_cap_code_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [6:0] hund_cnt_ff;
  logic [6:0] nxt_hund_cnt;
  logic [6:0] cap_mag;
  logic cap_wr;
  logic cap_bad;
  // Decode of analog trim writes; limits depend on the sign.
  assign cap_mag = reg_req_i.wdata[6:0];
  assign cap_wr = reg_req_i.wr && reg_req_i.addr == rdc_pkg::CAP_TRIM_OFS;
  assign cap_bad = reg_req_i.wdata[7] ? cap_mag > rdc_pkg::CAP_SUB_MAX
                                      : cap_mag > rdc_pkg::CAP_ADD_MAX;
  assign nxt_hund_cnt = sec_tick_o ? 7'h00 : hund_cnt_ff + 7'(hund_pulse_o);
  // Counts hundredths so a second can be judged whole, not pulse by pulse.
  always_ff @(posedge core_clk_i) begin
    hund_cnt_ff <= rst_b_i ? nxt_hund_cnt : 7'h00;
  end
  sec_whole_a: assert property (sec_tick_o |-> hund_pulse_o &&
    hund_cnt_ff == 7'h63) else $error("Second without 100 pulses.");
  hund_pulse_a: assert property (hund_pulse_o |=> !hund_pulse_o)
    else $error("Hundredth pulse too long.");
  corr_edge_a: assert property ($changed(corr_active_o) |-> sec_tick_o)
    else $error("Correction changed inside a second.");
  irq_pass_a: assert property (!freq_test_output_i |=>
    shared_irq_test_pin_o == $past(irq_level_i)) else $error("Pin lost irq.");
  // The pin follows a tick two edges late, so three quiet cycles leave it
  // settled at the next edge; ticks come four cycles apart at the densest.
  test_hold_a: assert property ((freq_test_output_i && !tick_1024_i)[*3]
    |=> $stable(shared_irq_test_pin_o)) else $error("Test pin moved.");
  rsv_bits_a: assert property (reg_req_i.rd &&
    reg_req_i.addr == rdc_pkg::RATE_TRIM_OFS |=> reg_rdata_o[7:6] == 2'b00)
    else $error("Reserved trim bits read set.");
  unmapped_a: assert property (reg_req_i.rd &&
    reg_req_i.addr != rdc_pkg::RATE_TRIM_OFS &&
    reg_req_i.addr != rdc_pkg::CAP_TRIM_OFS |=> reg_rdata_o == 8'h00)
    else $error("Unmapped read not zero.");
  cap_bad_a: assert property (cap_wr && cap_bad ##1 !reg_req_i.wr |=>
    load_cap_code_o == rdc_pkg::CAP_DEFAULT_CODE) else $error("Bad cap.");
  cap_good_a: assert property (cap_wr && !cap_bad ##1 !reg_req_i.wr |=>
    load_cap_code_o == $past(reg_req_i.wdata, 2)) else $error("Cap code.");
endmodule : rdc_calib_checker
bind rdc_calib rdc_calib_checker chk_u (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .tick_1024_i(tick_1024_i), .reg_req_i(reg_req_i),
  .freq_test_output_i(freq_test_output_i), .irq_level_i(irq_level_i),
  .reg_rdata_o(reg_rdata_o), .shared_irq_test_pin_o(shared_irq_test_pin_o),
  .hund_pulse_o(hund_pulse_o), .sec_tick_o(sec_tick_o),
  .corr_active_o(corr_active_o), .load_cap_code_o(load_cap_code_o));

// ---- bench/rdc_host_model.sv ----
/* Host software model: byte writes and reads on the register port.
   Assumes requests launch on falling edges of the core clock. */
`timescale 1ns/1ps
module rdc_host_model (
  // Clock.
  input wire logic core_clk_i,
  // Register port.
  input wire logic [7:0] reg_rdata_o,
  output rdc_pkg::rdc_reg_req_t reg_req_o
);
  initial reg_req_o = '0;
  // Rate trim is also rewritten while one of its corrected seconds is still under way.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i);
    reg_req_o = '0;
  endtask : wr
  // Data is taken a cycle and a half after the edge that samples the read.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk_i);
    reg_req_o = '0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask : rd
endmodule : rdc_host_model

// ---- bench/rdc_calib_tb.sv ----
/* Self-checking bench for the correction block.
   Assumes the host model drives the register port. */
`timescale 1ns/1ps
module rdc_calib_tb;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tick_1024_i = 1'b0;
  logic freq_test_output_i = 1'b0;
  logic irq_level_i = 1'b0;
  rdc_pkg::rdc_reg_req_t reg_req;
  logic [7:0] rdata;
  logic [7:0] cap_code;
  logic pin, hund, sec, corr;
  int err_total = 0;
  int samples_checked = 0;
  int tick_div = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  // Ticks four cycles apart, the densest spacing the block accepts.
  always @(negedge core_clk_i) begin
    tick_div <= (tick_div + 1) % 4;
    tick_1024_i <= tick_div == 3;
  end
  rdc_calib dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .tick_1024_i(tick_1024_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
    .freq_test_output_i(freq_test_output_i), .irq_level_i(irq_level_i),
    .shared_irq_test_pin_o(pin), .hund_pulse_o(hund), .sec_tick_o(sec),
    .corr_active_o(corr), .load_cap_code_o(cap_code));
  rdc_host_model host_u (.core_clk_i(core_clk_i), .reg_rdata_o(rdata),
    .reg_req_o(reg_req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One whole second: ticks, hundredths, test pin edges and correction.
  task automatic one_sec(input int ex_ticks, input logic ex_corr);
    int t, h, g;
    logic last, c;
    t = 0;
    h = 0;
    g = 0;
    last = pin;
    do begin
      @(posedge core_clk_i);
      t += int'(tick_1024_i);
      h += int'(hund);
      g += int'(pin != last);
      last = pin;
      if (!sec) c = corr;
    end while (!sec && t < 2000);
    chk(t[15:0], ex_ticks[15:0]);
    chk(h[15:0], 16'h0064);
    chk(g[15:0], t[15:0]);
    chk(c, ex_corr);
  endtask : one_sec
  task automatic pin_test;
    @(negedge core_clk_i);
    irq_level_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk(pin, 1'b1);
    freq_test_output_i = 1'b1;
  endtask : pin_test
  task automatic regs_test;
    logic [7:0] d;
    logic [7:0] code [5] = '{8'h27, 8'h28, 8'hC8, 8'hC9, 8'h80};
    logic [7:0] load [5] = '{8'h27, 8'h00, 8'hC8, 8'h00, 8'h80};
    host_u.rd(rdc_pkg::RATE_TRIM_OFS, d);
    chk(d, 8'h00);
    host_u.rd(8'h09, d);
    chk(d, 8'h00);
    host_u.wr(rdc_pkg::RATE_TRIM_OFS, 8'hFF);
    host_u.rd(rdc_pkg::RATE_TRIM_OFS, d);
    chk(d, 8'h3F);
    for (int i = 0; i < 5; i++) begin
      host_u.wr(rdc_pkg::CAP_TRIM_OFS, code[i]);
      host_u.rd(rdc_pkg::CAP_TRIM_OFS, d);
      chk(d, code[i]);
      chk(cap_code, load[i]);
    end
  endtask : regs_test
  task automatic fast_test;
    host_u.wr(rdc_pkg::RATE_TRIM_OFS, 8'h23);
    do @(posedge core_clk_i); while (!sec);
    one_sec(1022, 1'b1);
    one_sec(1022, 1'b1);
    one_sec(1024, 1'b0);
  endtask : fast_test
  task automatic slow_test;
    fork host_u.wr(rdc_pkg::RATE_TRIM_OFS, 8'h07); join_none
    one_sec(1024, 1'b0);
    one_sec(1026, 1'b1);
  endtask : slow_test
  task automatic zero_test;
    fork host_u.wr(rdc_pkg::RATE_TRIM_OFS, 8'h20); join_none
    one_sec(1026, 1'b1);
    one_sec(1024, 1'b0);
  endtask : zero_test
  task automatic results;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // Eight seconds, seven of them checked, of about 4100 cycles each should end well before this.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_total++;
    results();
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    pin_test();
    regs_test();
    fast_test();
    slow_test();
    zero_test();
    results();
  end
endmodule : rdc_calib_tb
